// ===== hdl/tas_pkg.sv
// tas_pkg: constants, register map and types of the thermal alarm register bank.
// assumes one system clock at 10 MHz; used by hdl/tas_regbank.sv.
package tas_pkg;

    // register offsets, which are also the command byte values
    localparam logic [7:0] OFS_REMOTE_TEMP  = 8'h00;
    localparam logic [7:0] OFS_LOCAL_TEMP   = 8'h01;
    localparam logic [7:0] OFS_CONFIG       = 8'h02;
    localparam logic [7:0] OFS_REMOTE_LIMIT = 8'h03;
    localparam logic [7:0] OFS_LOCAL_LIMIT  = 8'h04;
    localparam logic [7:0] OFS_STATUS       = 8'h05;
    localparam logic [7:0] OFS_MASK         = 8'h06;

    // values after reset
    localparam logic [7:0] RST_TEMP         = 8'h00;
    localparam logic [7:0] RST_CONFIG       = 8'h00;
    localparam logic [7:0] RST_REMOTE_LIMIT = 8'h6E;
    localparam logic [7:0] RST_LOCAL_LIMIT  = 8'h50;
    localparam logic [7:0] RST_STATUS       = 8'h00;
    localparam logic [7:0] RST_MASK         = 8'h00;
    localparam logic [7:0] RST_CMD          = 8'h00;

    // field positions
    localparam int BIT_REMOTE      = 7;
    localparam int BIT_LOCAL       = 6;
    localparam int BIT_TIMEOUT_DIS = 5;

    // writable bits: config bits 7:6 are reserved zero, mask holds 7:6 only
    localparam logic [7:0] WMASK_CONFIG = 8'h3F;
    localparam logic [7:0] WMASK_MASK   = 8'hC0;

    // arbitrary default bus address, chosen without meaning
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2A;

    // bus timing
    localparam int CLK_HZ         = 10_000_000;
    localparam int TIMEOUT_MS     = 25;
    localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int TOUT_W         = 18;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // serial state machine, gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ACK_ADDR = 3'b011,
        ST_RX       = 3'b010,
        ST_ACK_RX   = 3'b110,
        ST_TX       = 3'b111,
        ST_TX_ACK   = 3'b101
    } tas_state_t;

endpackage : tas_pkg

// ===== hdl/tas_regbank.sv
// tas_regbank: two-wire serial slave and register bank of the temperature monitor.
// assumes bus clock and data arrive from pins (synchronised here), and that the
// measurement results arrive on core_clk with a one-cycle valid strobe.
// Function
// - remote result at 00h, local at 01h
// - bytes weighted 128 C down to 1 C
// - read bytes shifted out msb first
// - both results read zero after reset
// - config byte at 02h, rw, resets zero
// - alert low when unmasked channel exceeds limit
// - limits reset to 6Eh remote, 50h local
// - status bit7 remote fault, bit6 local
// - status bits cleared only by reading them
// - status read releases the alert output
// - persisting fault sets bit and alert again
// - status register reads zero after reset
// - send byte sets command pointer only
// - mask bits 7 and 6 block alert
// - config bit5 zero enables bus timeout
module tas_regbank
    import tas_pkg::*;
#(
    parameter logic [6:0]   SLAVE_ADDR   = tas_pkg::DEF_SLAVE_ADDR,
    parameter int           TIMEOUT_CYC  = tas_pkg::TIMEOUT_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       smb_clk_i,
    input  wire logic       smb_data_i,
    output logic            smb_data_o,
    output logic            smb_data_oe,
    input  wire logic       meas_valid,
    input  wire logic [7:0] meas_remote,
    input  wire logic [7:0] meas_local,
    output logic            overtemp_alert_n_o,
    output logic            overtemp_alert_n_oe
);
    import tas_pkg::*;

    // register file readback; unmapped offsets read as zero
    function automatic logic [7:0] reg_read(
        input logic [7:0] ofs,
        input logic [7:0] rt, input logic [7:0] lt, input logic [7:0] cf,
        input logic [7:0] rl, input logic [7:0] ll, input logic [7:0] st,
        input logic [7:0] mk);
        logic [7:0] v;
        v = 8'h00;
        if (ofs == OFS_REMOTE_TEMP) begin
            v = rt;
        end else if (ofs == OFS_LOCAL_TEMP) begin
            v = lt;
        end else if (ofs == OFS_CONFIG) begin
            v = cf;
        end else if (ofs == OFS_REMOTE_LIMIT) begin
            v = rl;
        end else if (ofs == OFS_LOCAL_LIMIT) begin
            v = ll;
        end else if (ofs == OFS_STATUS) begin
            v = st;
        end else if (ofs == OFS_MASK) begin
            v = mk;
        end
        return v;
    endfunction

    // pin synchronisers; the first stage feeds only the second
    logic       scl_m_r;
    logic       scl_s_r;
    logic       scl_q_r;
    logic       sda_m_r;
    logic       sda_s_r;
    logic       sda_q_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= smb_clk_i;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= smb_data_i;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    assign scl_rise  = scl_s_r & ~scl_q_r;
    assign scl_fall  = ~scl_s_r & scl_q_r;
    assign start_det = scl_s_r & scl_q_r & ~sda_s_r & sda_q_r;
    assign stop_det  = scl_s_r & scl_q_r & sda_s_r & ~sda_q_r;

    // registers
    logic [7:0] remote_temperature_r;
    logic [7:0] local_temperature_r;
    logic [7:0] configuration_byte_r;
    logic [7:0] remote_overtemp_limit_r;
    logic [7:0] local_overtemp_limit_r;
    logic [7:0] overtemp_status_r;
    logic [7:0] overtemp_mask_r;

    // serial engine state
    tas_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] cmd_r;
    logic       got_cmd_r;
    logic       rd_dir_r;
    logic       ack_ok_r;
    logic [TOUT_W-1:0] tout_cnt_r;
    logic       tout_hit;

    // strobes from the serial engine
    logic       wr_stb;
    logic [7:0] wr_data;
    logic       status_rd;
    logic [7:0] rd_value;

    assign rd_value = reg_read(cmd_r, remote_temperature_r, local_temperature_r,
                               configuration_byte_r, remote_overtemp_limit_r,
                               local_overtemp_limit_r, overtemp_status_r,
                               overtemp_mask_r);

    // a low clock held past the limit frees the bus; config bit5 turns it off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_cnt_r <= '0;
        end else if (state_r == ST_IDLE || scl_s_r) begin
            tout_cnt_r <= '0;
        end else if (!tout_hit) begin
            tout_cnt_r <= tout_cnt_r + 1'b1;
        end
    end

    assign tout_hit = !configuration_byte_r[BIT_TIMEOUT_DIS] &&
                      (tout_cnt_r >= TOUT_W'(TIMEOUT_CYC));

    // byte level state machine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            rd_dir_r    <= 1'b0;
            ack_ok_r    <= 1'b0;
            got_cmd_r   <= 1'b0;
            smb_data_oe <= 1'b0;
        // a cut frame leaves no half-counted byte or data drive behind; ack_ok_r keeps its value
        end else if (tout_hit) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            got_cmd_r   <= 1'b0;
            smb_data_oe <= 1'b0;
        end else if (start_det) begin
            state_r     <= ST_ADDR;
            bit_cnt_r   <= 4'h0;
            got_cmd_r   <= 1'b0;
            ack_ok_r    <= 1'b0;
            smb_data_oe <= 1'b0;
        end else if (stop_det) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            got_cmd_r   <= 1'b0;
            smb_data_oe <= 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_RX: begin
                    if (scl_rise && bit_cnt_r < BITS_PER_BYTE) begin
                        shift_r   <= {shift_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                        if (state_r == ST_RX) begin
                            state_r     <= ST_ACK_RX;
                            smb_data_oe <= 1'b1;
                            got_cmd_r   <= 1'b1;
                        end else if (shift_r[7:1] == SLAVE_ADDR) begin
                            state_r     <= ST_ACK_ADDR;
                            rd_dir_r    <= shift_r[0];
                            smb_data_oe <= 1'b1;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rd_dir_r) begin
                            state_r     <= ST_TX;
                            shift_r     <= rd_value;
                            ack_ok_r    <= 1'b0;
                            smb_data_oe <= ~rd_value[7];
                        end else begin
                            state_r     <= ST_RX;
                            smb_data_oe <= 1'b0;
                        end
                    end
                end
                ST_ACK_RX: begin
                    if (scl_fall) begin
                        state_r     <= ST_RX;
                        bit_cnt_r   <= 4'h0;
                        smb_data_oe <= 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == BITS_PER_BYTE) begin
                            state_r     <= ST_TX_ACK;
                            smb_data_oe <= 1'b0;
                        end else begin
                            shift_r     <= {shift_r[6:0], 1'b0};
                            smb_data_oe <= ~shift_r[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_ok_r <= ~sda_s_r;
                    end else if (scl_fall) begin
                        if (ack_ok_r) begin
                            state_r     <= ST_TX;
                            bit_cnt_r   <= 4'h0;
                            shift_r     <= rd_value;
                            smb_data_oe <= ~rd_value[7];
                        end else begin
                            state_r <= ST_IDLE; // host not-acknowledge ends the read
                        end
                    end
                end
                default: begin
                    smb_data_oe <= 1'b0;
                end
            endcase
        end
    end

    // data line is open drain: only ever pulled low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smb_data_o <= 1'b0;
        end else begin
            smb_data_o <= 1'b0;
        end
    end

    // a byte that completes in receive is the command byte or else a data byte
    assign wr_stb  = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE)
                     && got_cmd_r && !tout_hit && !start_det && !stop_det;
    assign wr_data = shift_r;

    // status is cleared when a byte of it is loaded for sending
    assign status_rd = (cmd_r == OFS_STATUS) && scl_fall && !tout_hit && !start_det && !stop_det &&
                       ((state_r == ST_ACK_ADDR && rd_dir_r) || (state_r == ST_TX_ACK && ack_ok_r));

    // command pointer persists across transactions for later receive byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= RST_CMD;
        end else if (state_r == ST_RX && scl_fall && bit_cnt_r == BITS_PER_BYTE
                     && !got_cmd_r && !tout_hit && !start_det && !stop_det) begin
            cmd_r <= shift_r;
        end
    end

    // writable registers; results and status ignore writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            configuration_byte_r    <= RST_CONFIG;
            remote_overtemp_limit_r <= RST_REMOTE_LIMIT;
            local_overtemp_limit_r  <= RST_LOCAL_LIMIT;
            overtemp_mask_r         <= RST_MASK;
        end else if (wr_stb) begin
            if (cmd_r == OFS_CONFIG) begin
                configuration_byte_r <= wr_data & WMASK_CONFIG;
            end else if (cmd_r == OFS_REMOTE_LIMIT) begin
                remote_overtemp_limit_r <= wr_data;
            end else if (cmd_r == OFS_LOCAL_LIMIT) begin
                local_overtemp_limit_r <= wr_data;
            end else if (cmd_r == OFS_MASK) begin
                overtemp_mask_r <= wr_data & WMASK_MASK;
            end
        end
    end

    // measurement results, plain unsigned degrees
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_temperature_r <= RST_TEMP;
            local_temperature_r  <= RST_TEMP;
        end else if (meas_valid) begin
            remote_temperature_r <= meas_remote;
            local_temperature_r  <= meas_local;
        end
    end

    // fault flags: a set in the same cycle as a read wins, so no fault is lost
    logic [7:0] fault_set;

    always_comb begin
        fault_set = 8'h00;
        if (meas_valid) begin
            fault_set[BIT_REMOTE] = meas_remote > remote_overtemp_limit_r;
            fault_set[BIT_LOCAL]  = meas_local > local_overtemp_limit_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_status_r <= RST_STATUS;
        end else if (status_rd) begin
            overtemp_status_r <= fault_set;
        end else begin
            overtemp_status_r <= overtemp_status_r | fault_set;
        end
    end

    // alert follows unmasked flags; a status read drops flags so the pin floats
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_alert_n_oe <= 1'b0;
            overtemp_alert_n_o  <= 1'b0;
        end else begin
            overtemp_alert_n_oe <= |(overtemp_status_r & ~overtemp_mask_r
                                     & (8'h01 << BIT_REMOTE | 8'h01 << BIT_LOCAL));
            overtemp_alert_n_o  <= 1'b0;
        end
    end

endmodule // tas_regbank

// ===== tb/tas_host_model.sv
// tas_host_model: bit-level bus host talking to the register bank.
// assumes sda is the pulled-up wire level worked out by the bench; 800 ns bit period.
module tas_host_model (
    input  wire logic core_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    import tas_pkg::*;
    int nak = 0;
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // data set while the clock is low, sampled in mid high
    task automatic bitx(input logic b, output logic r);
        sda_lo = ~b;
        w(4);
        scl = 1'b1;
        w(2);
        r = sda;
        w(2);
        scl = 1'b0;
    endtask
    // long low before rising, so the device has let go of its ack first
    task automatic start();
        sda_lo = 1'b0;
        w(6);
        scl = 1'b1;
        w(4);
        sda_lo = 1'b1;
        w(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_lo = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sda_lo = 1'b0;
        w(4);
    endtask
    task automatic tx(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        if (r !== 1'b0) nak++;
    endtask
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, r);
    endtask
    // write byte, or send byte when has_d is low
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic has_d);
        start();
        tx({DEF_SLAVE_ADDR, 1'b0});
        tx(c);
        if (has_d) tx(d);
        stop();
    endtask
    // read byte, or receive byte when new_cmd is low
    task automatic rd(input logic [7:0] c, input logic new_cmd, output logic [7:0] d);
        if (new_cmd) begin
            start();
            tx({DEF_SLAVE_ADDR, 1'b0});
            tx(c);
        end
        start();
        tx({DEF_SLAVE_ADDR, 1'b1});
        rx(d);
        stop();
    endtask
endmodule // tas_host_model

// ===== tb/tas_regbank_properties.sv
// tas_regbank_properties: pin timing checks of the thermal alarm register bank.
// assumes bus clock low phases of four core_clk cycles or more; bound into tas_regbank.
module tas_regbank_properties
    import tas_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR  = tas_pkg::DEF_SLAVE_ADDR,
    parameter int         TIMEOUT_CYC = tas_pkg::TIMEOUT_CYCLES
) (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       smb_clk_i,
    input wire logic       smb_data_i,
    input wire logic       smb_data_o,
    input wire logic       smb_data_oe,
    input wire logic       meas_valid,
    input wire logic [7:0] meas_remote,
    input wire logic [7:0] meas_local,
    input wire logic       overtemp_alert_n_o,
    input wire logic       overtemp_alert_n_oe
);
    logic       clk_d_r;
    logic [3:0] fall_age_r;
    logic [1:0] hot_r;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // saturates at F so that long stalls and idle stay visible
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_d_r    <= 1'b1;
            fall_age_r <= 4'hF;
        end else begin
            clk_d_r <= smb_clk_i;
            if (clk_d_r && !smb_clk_i) fall_age_r <= 4'h0;
            else if (fall_age_r != 4'hF) fall_age_r <= fall_age_r + 4'h1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) hot_r <= 2'b00;
        else hot_r <= {hot_r[0], meas_valid && ((meas_remote | meas_local) != 8'h00)};
    end
    sequence clk_high8;
        smb_clk_i [*8];
    endsequence
    sequence clk_high3;
        smb_clk_i [*3];
    endsequence
    data_low_only_a: assert property (smb_data_o == 1'b0) else $error("data output value not low");
    alert_low_only_a: assert property (overtemp_alert_n_o == 1'b0) else $error("alert value not low");
    alert_cause_a: assert property ($rose(overtemp_alert_n_oe) |-> hot_r != 2'b00)
        else $error("alert rose without a hot measurement");
    alert_release_a: assert property ($fell(overtemp_alert_n_oe) |-> fall_age_r inside {[2:7]})
        else $error("alert released outside a bus slot");
    alert_hold_a: assert property (overtemp_alert_n_oe && fall_age_r == 4'hF |=> overtemp_alert_n_oe)
        else $error("alert dropped with the bus quiet");
    data_slot_a: assert property ($changed(smb_data_oe) |-> fall_age_r inside {[2:6]} || fall_age_r == 4'hF)
        else $error("data drive changed away from a clock fall");
    data_stands_a: assert property (clk_high3 |-> $stable(smb_data_oe))
        else $error("data drive changed while clock high");
    idle_release_a: assert property (clk_high8 |-> !smb_data_oe)
        else $error("data driven while bus idle");
endmodule // tas_regbank_properties

bind tas_regbank tas_regbank_properties #(.SLAVE_ADDR(SLAVE_ADDR), .TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .smb_clk_i(smb_clk_i), .smb_data_i(smb_data_i),
    .smb_data_o(smb_data_o), .smb_data_oe(smb_data_oe), .meas_valid(meas_valid),
    .meas_remote(meas_remote), .meas_local(meas_local),
    .overtemp_alert_n_o(overtemp_alert_n_o), .overtemp_alert_n_oe(overtemp_alert_n_oe));

// ===== tb/tas_regbank_tb_top.sv
// tas_regbank_tb_top: self-checking bench of the thermal alarm register bank.
// assumes tas_host_model as bus host; bus timeout shortened to 200 cycles.
module tas_regbank_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tas_pkg::*;
    logic       core_clk    = 1'b0;
    logic       rst_n       = 1'b0;
    logic       meas_valid  = 1'b0;
    logic [7:0] meas_remote = 8'h00;
    logic [7:0] meas_local  = 8'h00;
    logic       scl, sda_lo, data_o, data_oe, alert_o, alert_oe;
    wire        sda_w = !(sda_lo || (data_oe && !data_o));
    int         err_total = 0;
    int         n_checks  = 0;
    tas_host_model host_u (.core_clk(core_clk), .sda(sda_w), .scl(scl), .sda_lo(sda_lo));
    tas_regbank #(.TIMEOUT_CYC(200)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .smb_clk_i(scl), .smb_data_i(sda_w),
        .smb_data_o(data_o), .smb_data_oe(data_oe), .meas_valid(meas_valid),
        .meas_remote(meas_remote), .meas_local(meas_local),
        .overtemp_alert_n_o(alert_o), .overtemp_alert_n_oe(alert_oe));
    initial forever #50 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdc(input string what, input logic [7:0] c, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(c, 1'b1, d);
        chk(what, d, e);
    endtask
    task automatic meas(input logic [7:0] r, input logic [7:0] l);
        meas_remote = r;
        meas_local = l;
        meas_valid = 1'b1;
        @(posedge core_clk);
        #1 meas_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset();
        logic [7:0] rv [7] = '{RST_TEMP, RST_TEMP, RST_CONFIG, RST_REMOTE_LIMIT, RST_LOCAL_LIMIT, RST_STATUS, RST_MASK};
        chk("alert at reset", {7'h00, alert_oe}, 8'h00);
        for (int i = 0; i < 7; i++) rdc("reset value", 8'(i), rv[i]);
        rdc("unmapped", 8'h07, 8'h00);
        host_u.wr(OFS_REMOTE_TEMP, 8'h55, 1'b1);
        rdc("read-only result", OFS_REMOTE_TEMP, 8'h00);
    endtask
    task automatic t_alarm();
        meas(8'h6F, RST_LOCAL_LIMIT);
        rdc("remote temp", OFS_REMOTE_TEMP, 8'h6F);
        rdc("local temp", OFS_LOCAL_TEMP, 8'h50);
        chk("alert set", {7'h00, alert_oe}, 8'h01);
        rdc("status", OFS_STATUS, 8'h80);
        chk("alert released", {7'h00, alert_oe}, 8'h00);
        rdc("temp after status", OFS_REMOTE_TEMP, 8'h6F);
        rdc("status cleared", OFS_STATUS, 8'h00);
        meas(8'h6F, 8'h51);
        chk("alert again", {7'h00, alert_oe}, 8'h01);
        rdc("status again", OFS_STATUS, 8'hC0);
    endtask
    task automatic t_mask();
        host_u.wr(OFS_MASK, 8'hFF, 1'b1);
        rdc("mask", OFS_MASK, WMASK_MASK);
        host_u.wr(OFS_CONFIG, 8'hFF, 1'b1);
        rdc("config", OFS_CONFIG, WMASK_CONFIG);
        host_u.wr(OFS_CONFIG, 8'h00, 1'b1);
        meas(8'hFF, 8'hFF);
        chk("both masked", {7'h00, alert_oe}, 8'h00);
        rdc("masked status", OFS_STATUS, 8'hC0);
        host_u.wr(OFS_MASK, 8'h80, 1'b1);
        host_u.wr(OFS_LOCAL_LIMIT, 8'h60, 1'b1);
        rdc("local limit", OFS_LOCAL_LIMIT, 8'h60);
        meas(8'hFF, 8'h60);
        chk("at limit", {7'h00, alert_oe}, 8'h00);
        meas(8'hFF, 8'h61);
        chk("local above", {7'h00, alert_oe}, 8'h01);
        rdc("status both", OFS_STATUS, 8'hC0);
    endtask
    task automatic t_send();
        logic [7:0] d;
        host_u.wr(OFS_LOCAL_LIMIT, 8'h00, 1'b0);
        host_u.rd(8'h00, 1'b0, d);
        chk("receive after send", d, 8'h60);
        host_u.rd(8'h00, 1'b0, d);
        chk("receive repeated", d, 8'h60);
    endtask
    // stall the clock low while the device drives the first read bit
    task automatic t_tmo(input logic [7:0] cfg, input logic e);
        logic [7:0] d;
        host_u.wr(OFS_CONFIG, cfg, 1'b1);
        host_u.start();
        host_u.tx({DEF_SLAVE_ADDR, 1'b1});
        host_u.w(260);
        chk("stalled drive", {7'h00, data_oe}, {7'h00, e});
        host_u.rx(d);
        host_u.stop();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #5_000_000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_reset();
        t_alarm();
        t_mask();
        t_send();
        t_tmo(8'h00, 1'b0);
        t_tmo(8'h20, 1'b1);
        chk("host acks", 8'(host_u.nak), 8'h00);
        summarize();
    end
endmodule // tas_regbank_tb_top
